// ===== bench/asp_host_model.sv
// Host serial port that supplies the serial clock and shifts in the data line.
// Assumes the clock stands low between frames and the run input is set by the bench.
`default_nettype none

module asp_host_model (
    input wire logic run,          // High while a frame is clocked.
    input wire logic sdo,          // Serial data line from the converter.
    output logic sclk,             // Serial clock driven to the converter.
    output logic [31:0] got        // Bits taken at each rising clock edge.
);
    timeunit 1ns;
    timeprecision 100ps;

    // The clock runs only within a frame, 160 ns period, phase unrelated to the core.
    initial begin
        sclk = 1'b0;
        got = '0;
        forever begin
            wait (run);
            #83;
            while (run) begin
                sclk = 1'b1;
                got = {got[30:0], sdo};
                #80;
                sclk = 1'b0;
                #80;
            end
        end
    end
endmodule

`default_nettype wire

// ===== bench/asp_serial_port_tb.sv
// Self-checking bench of the converter serial output port.
// Assumes the host model beside it and the shared package compiled first.
`default_nettype none

module asp_serial_port_tb;
    import asp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b = 1'b1;
    logic rd_b = 1'b1;
    logic d7_in = 1'b0;
    logic conv_done = 1'b0;
    logic conv_busy = 1'b0;
    logic run = 1'b0;
    logic sclk;
    logic [31:0] got;
    logic [15:0] conv_data = '0;
    asp_cfg_t cfg = '0;
    asp_pins_t pins;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    asp_serial_port #(.SCLK_HALF(8)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .cfg_pins(cfg), .cs_b(cs_b), .rd_b(rd_b), .d7_in(d7_in), .d9_in(sclk),
        .conv_data(conv_data), .conv_done(conv_done), .conv_busy(conv_busy), .pins(pins));
    asp_host_model host (.run(run), .sdo(pins.d8.o), .sclk(sclk), .got(got));

    initial forever #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic set(input asp_cfg_t c, input logic en_b);
        @(posedge core_clk);
        cfg <= c;
        cs_b <= en_b;
        rd_b <= en_b;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic pulse(input logic [15:0] w);
        @(posedge core_clk);
        conv_data <= w;
        conv_done <= 1'b1;
        @(posedge core_clk);
        conv_done <= 1'b0;
    endtask

    task automatic par_test();
        logic [15:0] w;
        w = 16'hA5C3;
        set(5'h01, 1'b0);
        pulse(w);
        repeat (4) @(posedge core_clk);
        #1;
        chk({pins.d10.o, pins.d9.o, pins.d8.o, pins.d7.o}, w[10:7]);
        chk({pins.d10.oe_b, pins.d9.oe_b, pins.d8.oe_b, pins.d7.oe_b}, 0);
        set(5'h01, 1'b1);
        #1;
        chk({pins.d10.oe_b, pins.d9.oe_b, pins.d8.oe_b, pins.d7.oe_b}, 4'hF);
    endtask

    // Internal clock frame; the data bit is taken at each valid clock edge.
    task automatic master(input logic ic, input logic is, input logic rm, input logic [15:0] w);
        logic [15:0] s;
        // Mode is set with the port disabled so that a stale result cannot start a frame.
        set({1'b1, 1'b0, ic, is, 1'b0}, 1'b1);
        d7_in <= rm;
        conv_busy <= 1'b1;
        repeat (3) @(posedge core_clk);
        pulse(w);
        set({1'b1, 1'b0, ic, is, 1'b0}, 1'b0);
        if (!rm) begin
            repeat (20) @(posedge core_clk);
            #1;
            chk(pins.d10.o, is);
            @(posedge core_clk);
            conv_busy <= 1'b0;
        end
        for (int k = 0; k < 16; k++) begin
            do @(pins.d9.o); while (pins.d9.o !== ic);
            s[15-k] = pins.d8.o;
            chk(pins.d10.o, !is);
        end
        chk(s, w ^ 16'h8000);
        chk({pins.d9.oe_b, pins.d7.oe_b}, 2'h1);
        conv_busy <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        chk(pins.d10.o, is);
    endtask

    // Host clock frame of 32 periods; the chain level follows the word.
    task automatic slave();
        set(5'h19, 1'b0);
        d7_in <= 1'b1;
        repeat (3) @(posedge core_clk);
        pulse(16'h3C5A);
        repeat (6) @(posedge core_clk);
        run <= 1'b1;
        repeat (32) @(posedge sclk);
        run <= 1'b0;
        chk(pins.d10.o, 1'b1);
        chk({pins.d9.oe_b, pins.d7.oe_b}, 2'h3);
        chk(got, {16'h3C5A, 16'hFFFF});
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        par_test();
        master(1'b0, 1'b0, 1'b1, 16'h9F31);
        master(1'b1, 1'b1, 1'b0, 16'h0E72);
        slave();
        summarize();
    end
endmodule

`default_nettype wire

// ===== pkg/asp_pkg.sv
// Types shared by the converter serial output port.
// Assumes the constants header sits beside it on the include path.
`default_nettype none
`include "asp_regs.svh"

package asp_pkg;
    typedef struct packed {
        logic ser;      // High selects the serial port.
        logic ext;      // High selects the host-supplied serial clock.
        logic inv_clk;  // High moves data updates to the falling edge.
        logic inv_sync; // High makes the frame sync active low.
        logic coding;   // High gives straight binary.
    } asp_cfg_t;

    typedef struct packed {
        logic o;        // Level driven onto the pin.
        logic oe_b;     // Low while the pin is driven.
    } asp_pin_t;

    typedef struct packed {
        asp_pin_t d10;
        asp_pin_t d9;
        asp_pin_t d8;
        asp_pin_t d7;
    } asp_pins_t;

    typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} asp_state_t;
endpackage

`default_nettype wire

// ===== pkg/asp_regs.svh
// Constants of the converter serial output port: widths, counts and timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH

`define ASP_WORD_W 16
`define ASP_CHAIN_DELAY 16
`define ASP_CLK_NS 10
`define ASP_SCLK_HALF_NS 80
`define ASP_SCLK_HALF_CYC ((`ASP_SCLK_HALF_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`define ASP_SYNC_W 9

`endif

// ===== rtl/asp_serial_port.sv
// Output port of a 16-bit converter: parallel bits 7..10 or the serial port.
// Assumes conversion results arrive from logic on core_clk; all pins are asynchronous.
// How it works
// - Serial select low: shared pin drives parallel bit 7; high: it is an input.
// - Serial select low: data, clock and sync pins carry parallel bits 8, 9, 10.
// - In serial mode the bit 7 pin is chain input or read-mode select by clock source.
// - External clock: chain input level reaches data out after 16 serial clock periods.
// - Internal clock, read-mode high: shift result out while next conversion runs.
// - Internal clock, read-mode low: start serial output only after conversion completes.
// - Result held in a shift register and sent most significant bit first.
// - Output coding select input picks the coding of the serial word.
// - Coding select high gives straight binary; low inverts the MSB for two's complement.
// - Internal clock, no inversion: data changes on rising edge, valid at falling edge.
// - Clock invert high: data changes on falling edge, valid at rising edge.
// - Clock pin is output or input by clock source; invert picks the update edge.
// - Source low: device drives its clock out; high: host supplies the clock.
// - The device drives a frame sync output used with the internal clock.
// - Sync invert low: frame sync high from read start while data is valid.
// - Sync invert high: frame sync low from read start while data is valid.
// - Outputs are driven only while chip select and read are both low.
`default_nettype none
`include "asp_regs.svh"

module asp_serial_port
    import asp_pkg::*;
#(
    parameter int SCLK_HALF = `ASP_SCLK_HALF_CYC
) (
    input wire logic core_clk,                   // Core clock, 100 MHz.
    input wire logic rst_b,                      // Asynchronous reset, active low.
    input wire asp_cfg_t cfg_pins,               // Mode select pins.
    input wire logic cs_b,                       // Chip select pin, active low.
    input wire logic rd_b,                       // Read pin, active low.
    input wire logic d7_in,                      // Read-mode or chain input pin level.
    input wire logic d9_in,                      // Serial clock pin level from the host.
    input wire logic [`ASP_WORD_W-1:0] conv_data, // Conversion result.
    input wire logic conv_done,                  // One-cycle pulse: conv_data is new.
    input wire logic conv_busy,                  // Level: a conversion is in progress.
    output asp_pins_t pins                       // Shared pins 7 to 10.
);
    localparam int W = `ASP_WORD_W;

    asp_cfg_t cfg;
    logic cs_s, rd_s, rdc_s, sclk_s;
    logic sclk_d_r;
    logic [W-1:0] hold_r, shift_r;
    logic pend_r;
    asp_state_t st_r;
    logic sclk_int_r;
    logic [7:0] div_r;
    logic [4:0] bit_r;
    logic en, frame, start, tick, ext_upd;

    asp_sync #(.W(`ASP_SYNC_W)) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d({cfg_pins, cs_b, rd_b, d7_in, d9_in}),
        .q({cfg, cs_s, rd_s, rdc_s, sclk_s})
    );

    // Coding select high keeps straight binary; low flips the MSB.
    function automatic logic [W-1:0] code_word(input logic [W-1:0] w, input logic straight);
        code_word = {w[W-1] ^ ~straight, w[W-2:0]};
    endfunction

    assign en = !cs_s && !rd_s;
    assign frame = (st_r != ST_IDLE);
    // Read-mode high reads during conversion; low waits for it to finish.
    assign start = pend_r && en && cfg.ser && !frame &&
                   (cfg.ext || rdc_s || !conv_busy);
    assign tick = (div_r == 8'(SCLK_HALF - 1));
    // Host clock: update on rising edge, or falling edge when inverted.
    assign ext_upd = cfg.inv_clk ? (sclk_d_r && !sclk_s) : (!sclk_d_r && sclk_s);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
        end
    end

    // Result capture; a new result wins over the clear by a read start.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_r <= '0;
            pend_r <= 1'b0;
        end else begin
            if (conv_done) begin
                hold_r <= conv_data;
            end
            pend_r <= conv_done || (pend_r && !start);
        end
    end

    // Frame sequencing and the output shift register.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= ST_IDLE;
            shift_r <= '0;
            sclk_int_r <= 1'b0;
            div_r <= 8'h00;
            bit_r <= 5'h00;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    sclk_int_r <= 1'b0;
                    div_r <= 8'h00;
                    bit_r <= 5'h00;
                    if (start) begin
                        shift_r <= code_word(hold_r, cfg.coding);
                        if (cfg.ext) begin
                            st_r <= ST_SLAVE;
                        end else begin
                            st_r <= ST_MASTER;
                            sclk_int_r <= 1'b1;
                        end
                    end
                end
                ST_MASTER: begin
                    div_r <= tick ? 8'h00 : div_r + 8'h01;
                    if (!en || !cfg.ser || cfg.ext) begin
                        st_r <= ST_IDLE;
                    end else if (tick && sclk_int_r) begin
                        sclk_int_r <= 1'b0;
                        bit_r <= bit_r + 5'h01;
                    end else if (tick && bit_r == 5'(W)) begin
                        st_r <= ST_IDLE;
                    end else if (tick) begin
                        sclk_int_r <= 1'b1;
                        shift_r <= {shift_r[W-2:0], 1'b0};
                    end
                end
                ST_SLAVE: begin
                    if (!en || !cfg.ser || !cfg.ext) begin
                        st_r <= ST_IDLE;
                    end else if (ext_upd) begin
                        shift_r <= {shift_r[W-2:0], rdc_s};
                        if (bit_r != 5'(`ASP_CHAIN_DELAY)) begin
                            bit_r <= bit_r + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // Pin drive: parallel word bits, or the serial port.
    always_comb begin
        logic [W-1:0] par;
        par = code_word(hold_r, cfg.coding);
        if (!cfg.ser) begin
            pins.d7 = '{o: par[7], oe_b: !en};
            pins.d8 = '{o: par[8], oe_b: !en};
            pins.d9 = '{o: par[9], oe_b: !en};
            pins.d10 = '{o: par[10], oe_b: !en};
        end else begin
            pins.d7 = '{o: 1'b0, oe_b: 1'b1};
            pins.d8 = '{o: shift_r[W-1], oe_b: !en};
            pins.d9 = '{o: sclk_int_r ^ cfg.inv_clk, oe_b: !(en && !cfg.ext)};
            pins.d10 = '{o: frame ^ cfg.inv_sync, oe_b: !en};
        end
    end

    // Checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_idle_ready;
        st_r == ST_IDLE && pend_r && en && cfg.ser && !cfg.ext;
    endsequence
    sequence s_master_runs;
        st_r == ST_MASTER ##1 st_r == ST_MASTER;
    endsequence

    // Coding only touches bit 15, so bits 7 to 10 equal the held result.
    a_par_bit_seven: assert property (
        !cfg.ser |-> pins.d7.o == hold_r[7] && pins.d7.oe_b == !en)
        else $error("Parallel bit 7 not on shared pin.");
    a_serial_d7_input: assert property (cfg.ser |-> pins.d7.oe_b)
        else $error("Chain pin driven in serial mode.");
    a_par_upper_bits: assert property (
        !cfg.ser && en |-> pins.d8.o == hold_r[8] && pins.d9.o == hold_r[9] &&
        pins.d10.o == hold_r[10])
        else $error("Parallel bits 8 to 10 wrong.");
    a_load_coded_msb: assert property (
        st_r == ST_IDLE && start |=>
        shift_r[W-1] == ($past(hold_r[W-1]) ^ !$past(cfg.coding)))
        else $error("First bit is not the coded MSB.");
    a_readmode_wait: assert property (start && !cfg.ext && !rdc_s |-> !conv_busy)
        else $error("Read started during conversion with read-mode low.");
    a_readmode_during: assert property (
        s_idle_ready and (rdc_s && conv_busy) |=> st_r == ST_MASTER)
        else $error("Read did not start during conversion.");
    a_master_rise_update: assert property (
        s_master_runs ##0 $changed(shift_r[W-1]) |-> $rose(sclk_int_r))
        else $error("Data changed away from the internal rising edge.");
    a_slave_chain_shift: assert property (
        st_r == ST_SLAVE && en && cfg.ser && cfg.ext && ext_upd |=> shift_r[0] == $past(rdc_s))
        else $error("Chain input not shifted in.");
    a_sync_polarity: assert property (cfg.ser && frame |-> pins.d10.o == !cfg.inv_sync)
        else $error("Frame sync has the wrong level during a frame.");
    a_clock_pin_dir: assert property (cfg.ser && cfg.ext |-> pins.d9.oe_b)
        else $error("Clock pin driven with host clock selected.");
    a_outputs_gated: assert property (
        !en |-> pins.d8.oe_b && pins.d9.oe_b && pins.d10.oe_b && pins.d7.oe_b)
        else $error("Output driven without chip select and read.");
endmodule

`default_nettype wire

// ===== rtl/asp_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to core_clk.
`default_nettype none

module asp_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,   // Core clock.
    input wire logic rst_b,      // Asynchronous reset, active low.
    input wire logic [W-1:0] d,  // Asynchronous levels.
    output logic [W-1:0] q       // Synchronised levels.
);
    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

`default_nettype wire
